/* File: src/hhu_pkg.sv */
// constants, carrier type and behaviour list for the host transport uart
// Behaviour
// R1 - four-wire serial port, 115200 to 3.0 Mbps
// R2 - hardware measures line rate, reports divisor
// R3 - host command rewrites divisor, both switch
// R4 - 1040-byte receive and transmit queues
// R5 - queues reachable from internal bus side
// R6 - link carries h4 framed packets
// R7 - reset rate is 115.2 kbaud
// R8 - xoff pauses transmit, xon resumes
// R9 - slip delimiter and escape insertion/removal
// R10 - line edge while asleep raises wake
// R11 - rate from configuration load or detection
// R12 - mid-bit sampling tolerates 2% combined error
// R13 - divider gives exact and approximate rates
// R14 - transmit valid within 1.5 bits of cts
// R15 - host drops cts before stop midpoint
// R16 - rts high within 0.5 bit of stop
// R17 - 8n1 framing, lsb first, idle high
package hhu_pkg;

	// ==================================================================
	// timing
	localparam int unsigned CLK_HZ      = 100_000_000;
	localparam int unsigned RESET_BAUD  = 115_200;
	localparam int unsigned FAST_BAUD   = 3_000_000;
	localparam logic [15:0] DIV_RESET   = 16'((CLK_HZ + RESET_BAUD / 2) / RESET_BAUD);
	localparam logic [15:0] DIV_FASTEST = 16'(CLK_HZ / FAST_BAUD);
	localparam logic [15:0] DIV_ONE     = 16'h0001;
	localparam logic [3:0]  FRAME_BITS  = 4'ha;
	localparam logic [2:0]  LAST_DATA   = 3'h7;

	// ==================================================================
	// queues
	localparam int unsigned Q_DEPTH    = 1040;
	localparam logic [10:0] Q_LAST     = 11'h40f;
	localparam logic [10:0] Q_FULL     = 11'h410;
	localparam logic [10:0] RTS_LEVEL  = 11'h400;
	localparam logic [10:0] CNT_ONE    = 11'h001;

	// ==================================================================
	// in-band characters
	localparam logic [7:0] CH_XON      = 8'h11;
	localparam logic [7:0] CH_XOFF     = 8'h13;
	localparam logic [7:0] SLIP_END    = 8'hc0;
	localparam logic [7:0] SLIP_ESC    = 8'hdb;
	localparam logic [7:0] SLIP_ESC_E  = 8'hdc;
	localparam logic [7:0] SLIP_ESC_S  = 8'hdd;

	// ==================================================================
	// carrier
	typedef struct packed {
		logic       delim;
		logic [7:0] data;
	} hhu_word_s;

endpackage

/* File: src/hhu_fifo.sv */
// flip-flop character queue for the host transport uart
`timescale 1ns/1ns
module hhu_fifo (
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              in_valid,
	output logic                   in_ready,
	input  wire hhu_pkg::hhu_word_s in_data,
	output logic                   out_valid,
	input  wire logic              out_ready,
	output hhu_pkg::hhu_word_s     out_data,
	output logic [10:0]            level
);

	typedef struct packed {
		logic [hhu_pkg::Q_DEPTH-1:0][8:0] mem;
		logic [10:0]                      wr;
		logic [10:0]                      rd;
		logic [10:0]                      cnt;
	} hhu_fifo_state_s;

	hhu_fifo_state_s s;
	hhu_fifo_state_s next_s;
	logic            push;
	logic            pop;

	function automatic logic [10:0] hhu_wrap(input logic [10:0] p);
		hhu_wrap = (p == hhu_pkg::Q_LAST) ? 11'h000 : p + hhu_pkg::CNT_ONE;
	endfunction

	assign in_ready  = (s.cnt != hhu_pkg::Q_FULL);
	assign out_valid = (s.cnt != 11'h000);
	assign out_data  = s.mem[s.rd];
	assign level     = s.cnt;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// ==================================================================
	// next state
	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wr] = in_data;
			next_s.wr        = hhu_wrap(s.wr);
		end
		if (pop) begin
			next_s.rd = hhu_wrap(s.rd);
		end
		if (push && !pop) begin
			next_s.cnt = s.cnt + hhu_pkg::CNT_ONE;
		end else if (pop && !push) begin
			next_s.cnt = s.cnt - hhu_pkg::CNT_ONE;
		end
	end

	// storage keeps no reset: only pointers and count matter
	always_ff @(posedge clk) begin
		s.mem <= next_s.mem;
		if (!resetn) begin
			s.wr  <= 11'h000;
			s.rd  <= 11'h000;
			s.cnt <= 11'h000;
		end else begin
			s.wr  <= next_s.wr;
			s.rd  <= next_s.rd;
			s.cnt <= next_s.cnt;
		end
	end

endmodule // hhu_fifo

/* File: src/hhu_uart.sv */
// host transport uart: 8n1 serial engine, rate detection, flow control, slip
`timescale 1ns/1ns
module hhu_uart (
	input  wire logic               clk,
	input  wire logic               resetn,
	input  wire logic               serial_receive_line,
	output logic                    serial_transmit_line,
	input  wire logic               host_clear_to_send_n,
	output logic                    device_request_to_send_n,
	input  wire logic               div_load,
	input  wire logic [15:0]        div_value,
	input  wire logic               autobaud_start,
	output logic                    autobaud_done,
	output logic [15:0]             divisor,
	input  wire logic               sw_flow_en,
	output logic                    tx_paused,
	input  wire logic               slip_en,
	input  wire logic               sleep,
	output logic                    wake_req,
	input  wire logic               tx_in_valid,
	output logic                    tx_in_ready,
	input  wire hhu_pkg::hhu_word_s tx_in_data,
	output logic [10:0]             tx_level,
	output logic                    rx_out_valid,
	input  wire logic               rx_out_ready,
	output hhu_pkg::hhu_word_s      rx_out_data,
	output logic [10:0]             rx_level,
	output logic                    framing_error,
	output logic                    rx_overrun
);

	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} hhu_rx_e;

	typedef struct packed {
		logic [15:0]        div;
		logic               ab_armed;
		logic               ab_run;
		logic [15:0]        ab_cnt;
		logic               ab_done;
		logic [9:0]         tx_frame;
		logic [3:0]         tx_bits;
		logic [15:0]        tx_cnt;
		logic               esc_pend;
		logic [7:0]         esc_byte;
		logic               paused;
		hhu_rx_e            rx_st;
		logic [15:0]        rx_cnt;
		logic [2:0]         rx_bit;
		logic [7:0]         rx_shift;
		logic               rx_esc;
		logic               rx_push;
		hhu_pkg::hhu_word_s rx_word;
		logic               ferr;
		logic               ovr;
		logic               rts_n;
		logic               wake;
		logic               rx_prev;
		logic               cts_prev;
	} hhu_state_s;

	hhu_state_s         s;
	hhu_state_s         next_s;
	logic               txq_valid;
	logic               txq_pop;
	hhu_pkg::hhu_word_s txq_data;
	logic               rxq_ready;
	logic [7:0]         send;

	// ==================================================================
	// character queues
	hhu_fifo u_txq ( // see R4 see R5
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (tx_in_valid),
		.in_ready  (tx_in_ready),
		.in_data   (tx_in_data),
		.out_valid (txq_valid),
		.out_ready (txq_pop),
		.out_data  (txq_data),
		.level     (tx_level)
	);

	hhu_fifo u_rxq ( // see R4 see R5
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (s.rx_push),
		.in_ready  (rxq_ready),
		.in_data   (s.rx_word),
		.out_valid (rx_out_valid),
		.out_ready (rx_out_ready),
		.out_data  (rx_out_data),
		.level     (rx_level)
	);

	assign serial_transmit_line     = s.tx_frame[0];
	assign device_request_to_send_n = s.rts_n;
	assign autobaud_done            = s.ab_done;
	assign divisor                  = s.div;
	assign tx_paused                = s.paused;
	assign wake_req                 = s.wake;
	assign framing_error            = s.ferr;
	assign rx_overrun               = s.ovr;

	// ==================================================================
	// next state
	always_comb begin
		next_s         = s;
		txq_pop        = 1'b0;
		send           = 8'h00;
		next_s.ab_done = 1'b0;
		next_s.rx_push = 1'b0;
		next_s.ferr    = 1'b0;
		next_s.ovr     = 1'b0;
		next_s.rx_prev  = serial_receive_line;
		next_s.cts_prev = host_clear_to_send_n;

		// rate: host load wins over detection in the same cycle
		if (s.ab_armed && !s.ab_run && s.rx_prev && !serial_receive_line) begin
			next_s.ab_run = 1'b1; // see R2
			next_s.ab_cnt = hhu_pkg::DIV_ONE;
		end else if (s.ab_run) begin
			if (serial_receive_line) begin
				next_s.ab_run   = 1'b0; // see R2 see R11
				next_s.ab_armed = 1'b0;
				next_s.ab_done  = 1'b1;
				next_s.div      = (s.ab_cnt < hhu_pkg::DIV_FASTEST) ?
				                  hhu_pkg::DIV_FASTEST : s.ab_cnt;
			end else if (s.ab_cnt != 16'hffff) begin
				next_s.ab_cnt = s.ab_cnt + hhu_pkg::DIV_ONE;
			end
		end
		if (autobaud_start) begin
			next_s.ab_armed = 1'b1;
			next_s.ab_run   = 1'b0;
		end
		if (div_load) begin
			next_s.div = (div_value < hhu_pkg::DIV_FASTEST) ?
			             hhu_pkg::DIV_FASTEST : div_value; // see R3 see R11 see R1 see R13
		end

		// transmit: cts looked at only between characters
		if (s.tx_bits == 4'h0) begin
			if (!host_clear_to_send_n && s.esc_pend) begin
				send            = s.esc_byte; // see R9
				next_s.esc_pend = 1'b0;
				next_s.tx_bits  = hhu_pkg::FRAME_BITS;
			end else if (!host_clear_to_send_n && txq_valid && !s.paused) begin
				txq_pop        = 1'b1; // see R14 see R8
				next_s.tx_bits = hhu_pkg::FRAME_BITS;
				send           = txq_data.data;
				if (slip_en) begin
					if (txq_data.delim) begin
						send = hhu_pkg::SLIP_END; // see R9
					end else if (txq_data.data == hhu_pkg::SLIP_END) begin
						send            = hhu_pkg::SLIP_ESC;
						next_s.esc_pend = 1'b1;
						next_s.esc_byte = hhu_pkg::SLIP_ESC_E;
					end else if (txq_data.data == hhu_pkg::SLIP_ESC) begin
						send            = hhu_pkg::SLIP_ESC;
						next_s.esc_pend = 1'b1;
						next_s.esc_byte = hhu_pkg::SLIP_ESC_S;
					end
				end
			end
			if (next_s.tx_bits != 4'h0) begin
				next_s.tx_frame = {1'b1, send, 1'b0}; // see R17 see R6
				next_s.tx_cnt   = s.div - hhu_pkg::DIV_ONE;
			end
		end else if (s.tx_cnt == 16'h0000) begin
			next_s.tx_frame = {1'b1, s.tx_frame[9:1]};
			next_s.tx_bits  = s.tx_bits - 4'h1;
			next_s.tx_cnt   = s.div - hhu_pkg::DIV_ONE; // see R13
		end else begin
			next_s.tx_cnt = s.tx_cnt - hhu_pkg::DIV_ONE;
		end

		// receive: all samples at bit centre for rate margin
		case (s.rx_st)
			RX_IDLE: begin
				if (!s.ab_armed && !serial_receive_line) begin
					next_s.rx_st  = RX_START;
					next_s.rx_cnt = {1'b0, s.div[15:1]}; // see R12
				end
			end
			RX_START: begin
				if (s.rx_cnt != 16'h0000) begin
					next_s.rx_cnt = s.rx_cnt - hhu_pkg::DIV_ONE;
				end else if (serial_receive_line) begin
					next_s.rx_st = RX_IDLE;
				end else begin
					next_s.rx_st  = RX_DATA;
					next_s.rx_bit = 3'h0;
					next_s.rx_cnt = s.div - hhu_pkg::DIV_ONE;
				end
			end
			RX_DATA: begin
				if (s.rx_cnt != 16'h0000) begin
					next_s.rx_cnt = s.rx_cnt - hhu_pkg::DIV_ONE;
				end else begin
					next_s.rx_shift = {serial_receive_line, s.rx_shift[7:1]}; // see R17
					next_s.rx_bit   = s.rx_bit + 3'h1;
					next_s.rx_cnt   = s.div - hhu_pkg::DIV_ONE;
					if (s.rx_bit == hhu_pkg::LAST_DATA) begin
						next_s.rx_st = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (s.rx_cnt != 16'h0000) begin
					next_s.rx_cnt = s.rx_cnt - hhu_pkg::DIV_ONE;
				end else begin
					next_s.rx_st        = RX_IDLE;
					next_s.rx_word      = '{delim: 1'b0, data: s.rx_shift};
					if (!serial_receive_line) begin
						next_s.ferr = 1'b1;
					end else if (sw_flow_en && s.rx_shift == hhu_pkg::CH_XOFF) begin
						next_s.paused = 1'b1; // see R8
					end else if (sw_flow_en && s.rx_shift == hhu_pkg::CH_XON) begin
						next_s.paused = 1'b0; // see R8
					end else if (slip_en && s.rx_shift == hhu_pkg::SLIP_END) begin
						next_s.rx_push = 1'b1; // see R9
						next_s.rx_esc  = 1'b0;
						next_s.rx_word = '{delim: 1'b1, data: s.rx_shift};
					end else if (slip_en && !s.rx_esc && s.rx_shift == hhu_pkg::SLIP_ESC) begin
						next_s.rx_esc = 1'b1;
					end else begin
						next_s.rx_push = 1'b1;
						next_s.rx_esc  = 1'b0;
						if (slip_en && s.rx_esc && s.rx_shift == hhu_pkg::SLIP_ESC_E) begin
							next_s.rx_word.data = hhu_pkg::SLIP_END; // see R9
						end else if (slip_en && s.rx_esc && s.rx_shift == hhu_pkg::SLIP_ESC_S) begin
							next_s.rx_word.data = hhu_pkg::SLIP_ESC;
						end
					end
				end
			end
			default: begin
				next_s.rx_st = RX_IDLE;
			end
		endcase

		// a push into a full queue is dropped and flagged
		if (s.rx_push && !rxq_ready) begin
			next_s.ovr = 1'b1;
		end

		// throttle early: margin covers a host that ignores up to 16 more characters
		next_s.rts_n = (rx_level >= hhu_pkg::RTS_LEVEL); // see R16

		next_s.wake = sleep && ((serial_receive_line != s.rx_prev) ||
		                        (host_clear_to_send_n != s.cts_prev)); // see R10
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s          <= '0;
			s.div      <= hhu_pkg::DIV_RESET; // see R7
			s.tx_frame <= 10'h3ff;
			s.rx_st    <= RX_IDLE;
			s.rts_n    <= 1'b1;
			s.rx_prev  <= 1'b1;
			s.cts_prev <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

endmodule // hhu_uart

/* File: verification/hhu_uart_sva.sv */
// assertions for the host transport uart top module
`timescale 1ns/1ns
module hhu_uart_sva (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        serial_receive_line,
	input wire logic        serial_transmit_line,
	input wire logic        host_clear_to_send_n,
	input wire logic        device_request_to_send_n,
	input wire logic        div_load,
	input wire logic [15:0] div_value,
	input wire logic        autobaud_done,
	input wire logic [15:0] divisor,
	input wire logic        sw_flow_en,
	input wire logic        tx_paused,
	input wire logic        sleep,
	input wire logic        wake_req,
	input wire logic        tx_in_ready,
	input wire logic [10:0] tx_level,
	input wire logic [10:0] rx_level
);
	// ==================================================================
	// helper
	int low_run;
	// length of each low run; a wrong bit time leaves a remainder
	always_ff @(posedge clk) low_run <= (!resetn || serial_transmit_line) ? 0 : low_run + 1;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// ==================================================================
	// checks
	a_reset_idle: assert property (disable iff (1'b0)
		!resetn |=> serial_transmit_line && device_request_to_send_n) else $error("idle state lost");
	a_rts_full: assert property (rx_level >= 11'h400 |=> device_request_to_send_n)
		else $error("rts low with queue near full");
	a_rts_room: assert property (rx_level < 11'h400 |=> !device_request_to_send_n)
		else $error("rts high with room");
	a_bit_time: assert property ($rose(serial_transmit_line) |-> low_run % divisor == 0)
		else $error("low run not whole bits");
	a_div_load: assert property (div_load && div_value >= 16'h0021 |=>
		divisor == $past(div_value)) else $error("divisor not loaded");
	a_div_clamp: assert property (div_load && div_value < 16'h0021 |=>
		divisor == 16'h0021) else $error("divisor not clamped");
	a_div_cause: assert property ($changed(divisor) && $past(resetn) && !$past(div_load)
		|-> ##[0:1] autobaud_done) else $error("divisor changed without cause");
	a_done_pulse: assert property (autobaud_done |-> divisor >= 16'h0021 ##1 !autobaud_done)
		else $error("detection result bad");
	a_full_ready: assert property (tx_in_ready == (tx_level != 11'h410))
		else $error("ready not tied to fill");
	a_level_max: assert property (tx_level <= 11'h410 && rx_level <= 11'h410)
		else $error("queue over depth");
	a_pause_cause: assert property ($rose(tx_paused) |-> $past(sw_flow_en))
		else $error("pause without flow control");
	a_wake_edge: assert property (sleep && ($changed(host_clear_to_send_n)
		|| $changed(serial_receive_line)) |-> ##[1:3] wake_req) else $error("no wake");
	a_wake_quiet: assert property (!sleep && !$past(sleep) && !$past(sleep, 2) |-> !wake_req)
		else $error("wake while awake");
	c_done: cover property (autobaud_done);
	c_paused: cover property (tx_paused);
	c_wake: cover property (wake_req);
endmodule // hhu_uart_sva

bind hhu_uart hhu_uart_sva u_sva (.clk, .resetn, .serial_receive_line, .serial_transmit_line,
	.host_clear_to_send_n, .device_request_to_send_n, .div_load, .div_value, .autobaud_done,
	.divisor, .sw_flow_en, .tx_paused, .sleep, .wake_req, .tx_in_ready, .tx_level, .rx_level);

/* File: verification/hhu_host.sv */
// host side model of the serial link partner
`timescale 1ns/1ns
module hhu_host (
	input  wire logic clk,
	input  wire logic serial_transmit_line,
	output logic      serial_receive_line,
	output logic      host_clear_to_send_n
);
	int div = 868;
	initial begin
		serial_receive_line = 1'b1;
		host_clear_to_send_n = 1'b0;
	end
	// only moved between characters, well ahead of any stop bit
	task automatic set_cts(input logic v);
		@(posedge clk);
		#1 host_clear_to_send_n = v;
	endtask
	// same divisor as the device, so the combined error is nil
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			#1 serial_receive_line = f[i];
			repeat (div - 1) @(posedge clk);
		end
		// leave off the edge so the caller never races the design
		#1;
	endtask
	task automatic recv(output logic [7:0] d, output int w);
		w = 0;
		// look after the edge: txd is launched by the same edge
		while (serial_transmit_line !== 1'b0 && w < 4000) begin
			@(posedge clk);
			#1;
			w++;
		end
		repeat (div / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (div) @(posedge clk);
			d[i] = serial_transmit_line;
		end
		repeat (div) @(posedge clk);
		if (serial_transmit_line !== 1'b1) d = 8'hxx;
		#1;
	endtask
endmodule // hhu_host

/* File: verification/hhu_uart_tb.sv */
// self-checking bench for the host transport uart
`timescale 1ns/1ns
module hhu_uart_tb;
	logic               clk = 1'b0, resetn = 1'b0;
	logic               serial_receive_line, serial_transmit_line;
	logic               host_clear_to_send_n, device_request_to_send_n;
	logic               div_load, autobaud_start, autobaud_done, sw_flow_en, tx_paused;
	logic               slip_en, sleep, wake_req, tx_in_valid, tx_in_ready, hit;
	logic               rx_out_valid, rx_out_ready, framing_error, rx_overrun;
	logic [15:0]        div_value, divisor;
	logic [10:0]        tx_level, rx_level;
	logic [7:0]         b;
	hhu_pkg::hhu_word_s tx_in_data, rx_out_data;
	int                 w, fails = 0, comparisons = 0, cycles = 0;

	hhu_uart DUT (.clk, .resetn, .serial_receive_line, .serial_transmit_line,
		.host_clear_to_send_n, .device_request_to_send_n, .div_load, .div_value,
		.autobaud_start, .autobaud_done, .divisor, .sw_flow_en, .tx_paused, .slip_en, .sleep,
		.wake_req, .tx_in_valid, .tx_in_ready, .tx_in_data, .tx_level, .rx_out_valid,
		.rx_out_ready, .rx_out_data, .rx_level, .framing_error, .rx_overrun);
	hhu_host host (.clk, .serial_transmit_line, .serial_receive_line, .host_clear_to_send_n);

	always #5 clk = ~clk;
	// ==================================================================
	// helpers
	task automatic test_done;
		$display("counts: comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			test_done;
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic modes(input logic flow, input logic slip);
		sw_flow_en = flow;
		slip_en = slip;
	endtask
	// ready sampled at the falling edge, where it cannot race the taking edge
	task automatic push(input hhu_pkg::hhu_word_s v);
		logic r;
		tx_in_valid = 1'b1;
		tx_in_data = v;
		do begin
			@(negedge clk) r = tx_in_ready;
			@(posedge clk);
		end while (r !== 1'b1);
		#1 tx_in_valid = 1'b0;
	endtask
	task automatic pull(input logic [8:0] exp);
		for (int n = 0; n < 40 && rx_out_valid !== 1'b1; n++) tick(1);
		chk(16'(rx_out_data), 16'(exp));
		rx_out_ready = 1'b1;
		tick(1);
		rx_out_ready = 1'b0;
	endtask
	task automatic load(input logic [15:0] v, input logic [15:0] exp);
		div_load = 1'b1;
		div_value = v;
		tick(1);
		div_load = 1'b0;
		chk(divisor, exp);
	endtask
	// ==================================================================
	// scenarios
	task automatic t_reset;
		chk(divisor, 16'h0364);
		chk(16'(serial_transmit_line), 16'h0001);
		chk(16'(device_request_to_send_n), 16'h0000);
		chk(16'(tx_paused), 16'h0000);
		$display("test reset done");
	endtask
	task automatic t_rate;
		load(16'h0028, 16'h0028);
		tick(1);
		load(16'h0010, 16'h0021);
		host.div = 33;
		$display("test rate done");
	endtask
	task automatic t_tx;
		host.set_cts(1'b1);
		push(9'h001);
		tick(99);
		chk(16'(serial_transmit_line), 16'h0001);
		host.set_cts(1'b0);
		host.recv(b, w);
		chk(16'(b), 16'h0001);
		chk(16'(w <= 49), 16'h0001);
		host.send(8'ha5);
		pull(9'h0a5);
		$display("test tx rx done");
	endtask
	task automatic t_flow;
		modes(1'b1, 1'b0);
		host.send(8'h13);
		tick(40);
		chk(16'(tx_paused), 16'h0001);
		push(9'h055);
		tick(99);
		chk(16'(serial_transmit_line), 16'h0001);
		fork
			host.send(8'h11);
			host.recv(b, w);
		join
		tick(1);
		chk(16'(b), 16'h0055);
		chk(16'(tx_paused | (rx_level != 0)), 16'h0000);
		modes(1'b0, 1'b0);
		$display("test flow done");
	endtask
	task automatic t_slip;
		modes(1'b0, 1'b1);
		push(9'h0c0);
		host.recv(b, w);
		chk(16'(b), 16'h00db);
		host.recv(b, w);
		chk(16'(b), 16'h00dc);
		push(9'h1aa);
		host.recv(b, w);
		chk(16'(b), 16'h00c0);
		host.send(8'hdb);
		host.send(8'hdd);
		pull(9'h0db);
		host.send(8'hc0);
		pull(9'h1c0);
		modes(1'b0, 1'b0);
		$display("test slip done");
	endtask
	task automatic t_auto;
		autobaud_start = 1'b1;
		tick(1);
		autobaud_start = 1'b0;
		host.div = 40;
		host.send(8'h01);
		tick(2);
		chk(divisor, 16'h0028);
		$display("test detect done");
	endtask
	task automatic t_wake;
		for (int k = 1; k >= 0; k--) begin
			sleep = k[0];
			tick(2);
			host.set_cts(k[0]);
			hit = 1'b0;
			repeat (4) @(negedge clk) hit = hit | wake_req;
			chk(16'(hit), 16'(k));
		end
		$display("test wake done");
	endtask
	// fill the transmit queue with cts held off, then reset in mid-run
	task automatic t_full;
		host.set_cts(1'b1);
		tx_in_data = 9'h05a;
		tx_in_valid = 1'b1;
		tick(1040);
		tx_in_valid = 1'b0;
		chk(16'(tx_level), 16'h0410);
		chk(16'(tx_in_ready), 16'h0000);
		resetn = 1'b0;
		tick(2);
		resetn = 1'b1;
		tick(2);
		chk(16'(tx_level), 16'h0000);
		chk(divisor, 16'h0364);
		chk(16'(serial_transmit_line), 16'h0001);
		chk(16'(device_request_to_send_n), 16'h0000);
		host.set_cts(1'b0);
		$display("test full and reset done");
	endtask
	// ==================================================================
	// main sequence
	initial begin
		{div_load, autobaud_start, sleep, tx_in_valid, rx_out_ready} = '0;
		modes(1'b0, 1'b0);
		repeat (16) @(posedge clk);
		#1 resetn = 1'b1;
		tick(2);
		t_reset;
		t_rate;
		t_tx;
		t_flow;
		t_slip;
		t_auto;
		t_wake;
		t_full;
		test_done;
	end
endmodule // hhu_uart_tb
